/* File: src/serial_adapter_pkg.sv */
// Purpose: Shared constants, types and decode functions of the serial adapter core.
// Assumes: One clock domain; all pins are synchronised before use.
// Notes: Register layout, status bit positions and divider codes live here.
package serial_adapter_pkg;

   localparam int DATA_W = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int PIN_COUNT = 19;

   // Register select values.
   localparam logic OFFSET_CONFIG_STATE = 1'b0;
   localparam logic OFFSET_HOLDING = 1'b1;

   // Power-on value keeps the block in master reset until software releases it.
   localparam logic [7:0] LINE_CONFIG_RESET = 8'h03;

   // Field positions of line_config_reg.
   localparam int CFG_DIV_LSB = 0;
   localparam int CFG_WORD_LSB = 2;
   localparam int CFG_TX_CTL_LO = 5;
   localparam int CFG_TX_CTL_HI = 6;
   localparam int CFG_RX_IRQ_EN = 7;

   // Bit positions of line_state_reg.
   localparam int ST_RX_FULL = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_CARRIER = 2;
   localparam int ST_CLEAR_TO_SEND = 3;
   localparam int ST_FRAMING = 4;
   localparam int ST_OVERRUN = 5;
   localparam int ST_PARITY = 6;
   localparam int ST_IRQ = 7;

   // Divider codes and bit-clock ratios.
   localparam logic [1:0] DIV_BY_1 = 2'h0;
   localparam logic [1:0] DIV_BY_16 = 2'h1;
   localparam logic [1:0] DIV_BY_64 = 2'h2;
   localparam logic [1:0] DIV_MASTER_RESET = 2'h3;
   localparam logic [6:0] RATIO_1 = 7'h01;
   localparam logic [6:0] RATIO_16 = 7'h10;
   localparam logic [6:0] RATIO_64 = 7'h40;

   typedef enum logic [4:0] {
      TX_IDLE = 5'b00001,
      TX_START = 5'b00010,
      TX_DATA = 5'b00100,
      TX_PARITY = 5'b01000,
      TX_STOP = 5'b10000
   } tx_state_t;

   typedef enum logic [4:0] {
      RX_IDLE = 5'b00001,
      RX_START = 5'b00010,
      RX_DATA = 5'b00100,
      RX_PARITY = 5'b01000,
      RX_STOP = 5'b10000
   } rx_state_t;

   function automatic logic [6:0] bit_ratio(input logic [1:0] div);
      bit_ratio = (div == DIV_BY_16) ? RATIO_16 : (div == DIV_BY_64) ? RATIO_64 : RATIO_1;
   endfunction : bit_ratio

   // Index of the last data bit: 7 for eight data bits, 6 for seven.
   function automatic logic [2:0] last_data_bit(input logic [2:0] word);
      last_data_bit = word[2] ? 3'h7 : 3'h6;
   endfunction : last_data_bit

   function automatic logic parity_on(input logic [2:0] word);
      parity_on = ~word[2] | word[1];
   endfunction : parity_on

   function automatic logic parity_odd(input logic [2:0] word);
      parity_odd = word[0];
   endfunction : parity_odd

   function automatic logic stop_two(input logic [2:0] word);
      stop_two = ~word[1] & (~word[2] | ~word[0]);
   endfunction : stop_two

endpackage : serial_adapter_pkg

/* File: src/pin_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of asynchronous pins.
// Assumes: Each bit is independent; multi-bit words are sampled under a strobe.
// Notes: Only the second stage is visible outside.
`timescale 1ns/1ps
module pin_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_reg;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         meta_reg <= '0;
         q_o <= '0;
      end else begin
         meta_reg <= d_i;
         q_o <= meta_reg;
      end
   end
endmodule : pin_sync

/* File: src/byte_fifo.sv */
// Purpose: Small synchronous FIFO with valid/ready on both sides.
// Assumes: DEPTH is a power of two.
// Notes: clear_i empties the FIFO without touching the stored words.
`timescale 1ns/1ps
module byte_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic clear_i,
   input wire logic wr_valid_i,
   output logic wr_ready_o,
   input wire logic [WIDTH-1:0] wr_data_i,
   output logic rd_valid_o,
   input wire logic rd_ready_i,
   output logic [WIDTH-1:0] rd_data_o
);
   localparam int AW = $clog2(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_ptr_reg;
   logic [AW:0] rd_ptr_reg;
   logic push;
   logic pop;

   assign wr_ready_o = (wr_ptr_reg[AW-1:0] != rd_ptr_reg[AW-1:0]) ||
                       (wr_ptr_reg[AW] == rd_ptr_reg[AW]);
   assign rd_valid_o = (wr_ptr_reg != rd_ptr_reg);
   assign rd_data_o = mem[rd_ptr_reg[AW-1:0]];
   assign push = wr_valid_i & wr_ready_o;
   assign pop = rd_valid_o & rd_ready_i;

   always_ff @(posedge clk_i) begin
      if (push) begin
         mem[wr_ptr_reg[AW-1:0]] <= wr_data_i;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else if (clear_i) begin
         wr_ptr_reg <= '0;
         rd_ptr_reg <= '0;
      end else begin
         wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
         rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
      end
   end
endmodule : byte_fifo

/* File: src/async_serial_adapter_core.sv */
// Purpose: Asynchronous serial adapter core behind a strobed 8-bit register bus.
// Assumes: All pins, bit clocks included, are oversampled by mclk_i at 40 MHz.
// Notes: Bus accesses act on the falling edge of the bus enable strobe.
`timescale 1ns/1ps
module async_serial_adapter_core (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic bus_enable_i,
   input wire logic read_write_i,
   input wire logic register_select_i,
   input wire logic chip_select_a_i,
   input wire logic chip_select_b_i,
   input wire logic chip_select_c_n_i,
   input wire logic [7:0] data_i,
   output logic [7:0] data_o,
   output logic data_oe_o,
   input wire logic tx_bit_clk_i,
   input wire logic rx_bit_clk_i,
   input wire logic rx_serial_i,
   input wire logic clear_to_send_n_i,
   input wire logic carrier_detect_n_i,
   output logic tx_serial_o,
   output logic request_to_send_n_o,
   output logic irq_n_o,
   output logic irq_oe_o
);
   logic [serial_adapter_pkg::PIN_COUNT-1:0] pin_raw;
   logic [serial_adapter_pkg::PIN_COUNT-1:0] pin_q;

   assign pin_raw = {bus_enable_i, read_write_i, register_select_i, chip_select_a_i,
                     chip_select_b_i, chip_select_c_n_i, data_i, tx_bit_clk_i,
                     rx_bit_clk_i, rx_serial_i, clear_to_send_n_i, carrier_detect_n_i};

   pin_sync #(.WIDTH(serial_adapter_pkg::PIN_COUNT)) pins_u (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .d_i(pin_raw),
      .q_o(pin_q)
   );

   wire e_s = pin_q[18];
   wire rw_s = pin_q[17];
   wire rs_s = pin_q[16];
   wire sel_s = pin_q[15] & pin_q[14] & ~pin_q[13];
   wire [7:0] wdata_s = pin_q[12:5];
   wire txclk_s = pin_q[4];
   wire rxclk_s = pin_q[3];
   wire rxd_s = pin_q[2];
   wire cts_high = pin_q[1];
   wire dcd_high = pin_q[0];

   // Edge detection on the synchronised strobe, bit clocks and carrier.
   logic e_prev_reg;
   logic txclk_prev_reg;
   logic rxclk_prev_reg;
   logic dcd_prev_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         e_prev_reg <= 1'b0;
         txclk_prev_reg <= 1'b0;
         rxclk_prev_reg <= 1'b0;
         dcd_prev_reg <= 1'b0;
      end else begin
         e_prev_reg <= e_s;
         txclk_prev_reg <= txclk_s;
         rxclk_prev_reg <= rxclk_s;
         dcd_prev_reg <= dcd_high;
      end
   end

   wire e_fall = e_prev_reg & ~e_s;
   wire tx_fall = txclk_prev_reg & ~txclk_s;
   wire rx_rise = ~rxclk_prev_reg & rxclk_s;
   wire dcd_rise = ~dcd_prev_reg & dcd_high;

   // Bus access captured while the strobe is high, acted on at its fall.
   logic acc_sel_reg;
   logic acc_rs_reg;
   logic acc_rw_reg;
   logic [7:0] acc_data_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         acc_sel_reg <= 1'b0;
         acc_rs_reg <= 1'b0;
         acc_rw_reg <= 1'b0;
         acc_data_reg <= 8'h00;
      end else if (e_s) begin
         acc_sel_reg <= sel_s;
         acc_rs_reg <= rs_s;
         acc_rw_reg <= rw_s;
         acc_data_reg <= wdata_s;
      end
   end

   wire acc_go = e_fall & acc_sel_reg;
   wire wr_cfg = acc_go & ~acc_rw_reg & (acc_rs_reg == serial_adapter_pkg::OFFSET_CONFIG_STATE);
   wire wr_tx = acc_go & ~acc_rw_reg & (acc_rs_reg == serial_adapter_pkg::OFFSET_HOLDING);
   wire rd_stat = acc_go & acc_rw_reg & (acc_rs_reg == serial_adapter_pkg::OFFSET_CONFIG_STATE);
   wire rd_rx = acc_go & acc_rw_reg & (acc_rs_reg == serial_adapter_pkg::OFFSET_HOLDING);

   logic [7:0] line_config_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         line_config_reg <= serial_adapter_pkg::LINE_CONFIG_RESET;
      end else if (wr_cfg) begin
         line_config_reg <= acc_data_reg;
      end
   end

   wire [1:0] div_sel = line_config_reg[serial_adapter_pkg::CFG_DIV_LSB +: 2];
   wire [2:0] word = line_config_reg[serial_adapter_pkg::CFG_WORD_LSB +: 3];
   wire ctl_lo = line_config_reg[serial_adapter_pkg::CFG_TX_CTL_LO];
   wire ctl_hi = line_config_reg[serial_adapter_pkg::CFG_TX_CTL_HI];
   wire mreset = (div_sel == serial_adapter_pkg::DIV_MASTER_RESET);
   wire tx_irq_enable = ctl_lo & ~ctl_hi;
   wire send_break = ctl_lo & ctl_hi;
   wire rts_high = ctl_hi & ~ctl_lo;
   wire rx_irq_enable = line_config_reg[serial_adapter_pkg::CFG_RX_IRQ_EN];
   wire [6:0] ratio = serial_adapter_pkg::bit_ratio(div_sel);
   wire [6:0] half_last = (ratio >> 1) - 7'h01;
   wire [2:0] last_bit = serial_adapter_pkg::last_data_bit(word);
   wire par_en = serial_adapter_pkg::parity_on(word);
   wire par_odd = serial_adapter_pkg::parity_odd(word);

   // Transmit holding register feeding the FIFO in front of the shifter.
   logic [7:0] tx_holding_reg;
   logic holding_full_reg;
   logic fifo_in_ready;
   logic fifo_out_valid;
   logic [7:0] fifo_out_data;
   logic tx_take;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_holding_reg <= 8'h00;
         holding_full_reg <= 1'b0;
      end else begin
         if (wr_tx) begin
            tx_holding_reg <= acc_data_reg;
         end
         holding_full_reg <= wr_tx | (holding_full_reg & ~fifo_in_ready & ~mreset);
      end
   end

   byte_fifo #(
      .WIDTH(serial_adapter_pkg::DATA_W),
      .DEPTH(serial_adapter_pkg::FIFO_DEPTH)
   ) tx_fifo_u (
      .clk_i(mclk_i),
      .rst_n_i(rst_n_i),
      .clear_i(mreset),
      .wr_valid_i(holding_full_reg & ~mreset),
      .wr_ready_o(fifo_in_ready),
      .wr_data_i(tx_holding_reg),
      .rd_valid_o(fifo_out_valid),
      .rd_ready_i(tx_take),
      .rd_data_o(fifo_out_data)
   );

   // Transmit shifter, stepping once per bit period on falling bit-clock edges.
   serial_adapter_pkg::tx_state_t tx_state_reg;
   logic [6:0] tx_div_reg;
   logic [7:0] tx_sr_reg;
   logic tx_par_reg;
   logic [2:0] tx_cnt_reg;
   logic tx_line_reg;

   wire tx_bnd = tx_fall & (tx_div_reg == ratio - 7'h01);
   wire tx_last_stop = ~serial_adapter_pkg::stop_two(word) | (tx_cnt_reg == 3'h1);
   assign tx_take = tx_bnd & ~mreset & ((tx_state_reg == serial_adapter_pkg::TX_IDLE) |
                    ((tx_state_reg == serial_adapter_pkg::TX_STOP) & tx_last_stop));
   wire tx_pop = tx_take & fifo_out_valid;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_state_reg <= serial_adapter_pkg::TX_IDLE;
         tx_div_reg <= 7'h00;
         tx_sr_reg <= 8'h00;
         tx_par_reg <= 1'b0;
         tx_cnt_reg <= 3'h0;
         tx_line_reg <= 1'b1;
      end else if (mreset) begin
         tx_state_reg <= serial_adapter_pkg::TX_IDLE;
         tx_div_reg <= 7'h00;
         tx_line_reg <= 1'b1;
      end else begin
         if (tx_fall) begin
            tx_div_reg <= tx_bnd ? 7'h00 : tx_div_reg + 7'h01;
         end
         if (tx_pop) begin
            tx_state_reg <= serial_adapter_pkg::TX_START;
            tx_line_reg <= 1'b0;
            tx_sr_reg <= fifo_out_data;
         end else if (tx_bnd) begin
            unique case (tx_state_reg)
               serial_adapter_pkg::TX_IDLE: begin
                  tx_line_reg <= 1'b1;
               end
               serial_adapter_pkg::TX_START: begin
                  tx_line_reg <= tx_sr_reg[0];
                  tx_par_reg <= tx_sr_reg[0];
                  tx_cnt_reg <= 3'h0;
                  tx_state_reg <= serial_adapter_pkg::TX_DATA;
               end
               serial_adapter_pkg::TX_DATA: begin
                  if (tx_cnt_reg == last_bit) begin
                     tx_cnt_reg <= 3'h0;
                     if (par_en) begin
                        tx_line_reg <= tx_par_reg ^ par_odd;
                        tx_state_reg <= serial_adapter_pkg::TX_PARITY;
                     end else begin
                        tx_line_reg <= 1'b1;
                        tx_state_reg <= serial_adapter_pkg::TX_STOP;
                     end
                  end else begin
                     tx_line_reg <= tx_sr_reg[1];
                     tx_sr_reg <= {1'b0, tx_sr_reg[7:1]};
                     tx_par_reg <= tx_par_reg ^ tx_sr_reg[1];
                     tx_cnt_reg <= tx_cnt_reg + 3'h1;
                  end
               end
               serial_adapter_pkg::TX_PARITY: begin
                  tx_line_reg <= 1'b1;
                  tx_cnt_reg <= 3'h0;
                  tx_state_reg <= serial_adapter_pkg::TX_STOP;
               end
               serial_adapter_pkg::TX_STOP: begin
                  if (tx_last_stop) begin
                     tx_state_reg <= serial_adapter_pkg::TX_IDLE;
                  end else begin
                     tx_cnt_reg <= 3'h1;
                  end
               end
               default: begin
                  tx_state_reg <= serial_adapter_pkg::TX_IDLE;
                  tx_line_reg <= 1'b1;
               end
            endcase
         end
      end
   end

   // Receive deserialiser.
   serial_adapter_pkg::rx_state_t rx_state_reg;
   logic [6:0] rx_cnt_reg;
   logic [2:0] rx_idx_reg;
   logic [7:0] rx_sr_reg;
   logic rx_par_reg;
   logic rx_pend_pe_reg;

   wire rx_hold = mreset | dcd_high;
   wire rx_samp = rx_rise & (rx_cnt_reg == ratio - 7'h01);
   wire [6:0] rx_cnt_step = rx_samp ? 7'h00 : rx_cnt_reg + 7'h01;
   wire rx_done = rx_samp & (rx_state_reg == serial_adapter_pkg::RX_STOP);

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_state_reg <= serial_adapter_pkg::RX_IDLE;
         rx_cnt_reg <= 7'h00;
         rx_idx_reg <= 3'h0;
         rx_sr_reg <= 8'h00;
         rx_par_reg <= 1'b0;
         rx_pend_pe_reg <= 1'b0;
      end else if (rx_hold) begin
         rx_state_reg <= serial_adapter_pkg::RX_IDLE;
         rx_cnt_reg <= 7'h00;
      end else begin
         unique case (rx_state_reg)
            serial_adapter_pkg::RX_IDLE: begin
               rx_cnt_reg <= 7'h00;
               rx_idx_reg <= 3'h0;
               rx_sr_reg <= 8'h00;
               rx_par_reg <= 1'b0;
               rx_pend_pe_reg <= 1'b0;
               if (rx_rise && !rxd_s) begin
                  if (ratio == serial_adapter_pkg::RATIO_1) begin
                     rx_state_reg <= serial_adapter_pkg::RX_DATA;
                  end else begin
                     rx_cnt_reg <= 7'h01;
                     rx_state_reg <= serial_adapter_pkg::RX_START;
                  end
               end
            end
            serial_adapter_pkg::RX_START: begin
               if (rx_rise) begin
                  if (rxd_s) begin
                     rx_state_reg <= serial_adapter_pkg::RX_IDLE;
                  end else if (rx_cnt_reg == half_last) begin
                     rx_cnt_reg <= 7'h00;
                     rx_state_reg <= serial_adapter_pkg::RX_DATA;
                  end else begin
                     rx_cnt_reg <= rx_cnt_reg + 7'h01;
                  end
               end
            end
            serial_adapter_pkg::RX_DATA: begin
               if (rx_rise) begin
                  rx_cnt_reg <= rx_cnt_step;
               end
               if (rx_samp) begin
                  rx_sr_reg[rx_idx_reg] <= rxd_s;
                  rx_par_reg <= rx_par_reg ^ rxd_s;
                  rx_idx_reg <= rx_idx_reg + 3'h1;
                  if (rx_idx_reg == last_bit) begin
                     rx_state_reg <= par_en ? serial_adapter_pkg::RX_PARITY :
                                     serial_adapter_pkg::RX_STOP;
                  end
               end
            end
            serial_adapter_pkg::RX_PARITY: begin
               if (rx_rise) begin
                  rx_cnt_reg <= rx_cnt_step;
               end
               if (rx_samp) begin
                  rx_pend_pe_reg <= rx_par_reg ^ rxd_s ^ par_odd;
                  rx_state_reg <= serial_adapter_pkg::RX_STOP;
               end
            end
            serial_adapter_pkg::RX_STOP: begin
               if (rx_rise) begin
                  rx_cnt_reg <= rx_cnt_step;
               end
               if (rx_samp) begin
                  rx_state_reg <= serial_adapter_pkg::RX_IDLE;
               end
            end
            default: begin
               rx_state_reg <= serial_adapter_pkg::RX_IDLE;
            end
         endcase
      end
   end

   // Receive holding register and status flags; hardware sets win over read clears; master reset wins over all but the framing and parity sets.
   logic [7:0] rx_holding_reg;
   logic rx_full_reg;
   logic overrun_reg;
   logic framing_reg;
   logic parity_err_reg;
   logic carrier_latch_reg;
   logic stat_seen_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_holding_reg <= 8'h00;
         framing_reg <= 1'b0;
         parity_err_reg <= 1'b0;
         stat_seen_reg <= 1'b0;
      end else begin
         if (rx_done && !rx_full_reg) begin
            rx_holding_reg <= rx_sr_reg;
            framing_reg <= ~rxd_s;
            parity_err_reg <= rx_pend_pe_reg;
         end else if (mreset) begin
            framing_reg <= 1'b0;
            parity_err_reg <= 1'b0;
         end
         if (acc_go) begin
            stat_seen_reg <= rd_stat;
         end
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_full_reg <= 1'b0;
         overrun_reg <= 1'b0;
         carrier_latch_reg <= 1'b0;
      end else if (mreset) begin
         rx_full_reg <= 1'b0;
         overrun_reg <= 1'b0;
         carrier_latch_reg <= 1'b0;
      end else begin
         if (rx_done && !rx_full_reg) begin
            rx_full_reg <= 1'b1;
         end else if (rd_rx) begin
            rx_full_reg <= 1'b0;
         end
         if (rx_done && rx_full_reg) begin
            overrun_reg <= 1'b1;
         end else if (rd_rx && stat_seen_reg) begin
            overrun_reg <= 1'b0;
         end
         if (dcd_rise) begin
            carrier_latch_reg <= 1'b1;
         end else if (rd_rx && stat_seen_reg) begin
            carrier_latch_reg <= 1'b0;
         end
      end
   end

   wire rx_full_vis = rx_full_reg & ~dcd_high;
   wire tx_empty_vis = ~holding_full_reg & ~cts_high;
   wire irq_cause = ~mreset & ((rx_irq_enable & (rx_full_vis | overrun_reg | carrier_latch_reg)) |
                    (tx_irq_enable & tx_empty_vis));

   logic [7:0] line_state_reg;
   assign line_state_reg[serial_adapter_pkg::ST_RX_FULL] = rx_full_vis;
   assign line_state_reg[serial_adapter_pkg::ST_TX_EMPTY] = tx_empty_vis;
   assign line_state_reg[serial_adapter_pkg::ST_CARRIER] = carrier_latch_reg | dcd_high;
   assign line_state_reg[serial_adapter_pkg::ST_CLEAR_TO_SEND] = cts_high;
   assign line_state_reg[serial_adapter_pkg::ST_FRAMING] = framing_reg;
   assign line_state_reg[serial_adapter_pkg::ST_OVERRUN] = overrun_reg;
   assign line_state_reg[serial_adapter_pkg::ST_PARITY] = parity_err_reg;
   assign line_state_reg[serial_adapter_pkg::ST_IRQ] = irq_cause;

   wire [7:0] read_mux = rs_s ? rx_holding_reg : line_state_reg;

   always_ff @(posedge mclk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
         irq_n_o <= 1'b1;
         irq_oe_o <= 1'b0;
         request_to_send_n_o <= 1'b0;
         tx_serial_o <= 1'b1;
      end else begin
         data_o <= read_mux;
         data_oe_o <= e_s & sel_s & rw_s;
         irq_n_o <= ~irq_cause;
         irq_oe_o <= irq_cause;
         request_to_send_n_o <= rts_high;
         tx_serial_o <= tx_line_reg & ~send_break;
      end
   end
endmodule : async_serial_adapter_core

/* File: verif/async_serial_adapter_core_checker.sv */
// Purpose: Port assertions for the serial adapter core.
// Assumes: The bench holds the select lines 6 clocks past the strobe.
// Notes: Bound into the core below.
`timescale 1ns/1ps
module async_serial_adapter_core_checker (
   input wire logic mclk_i,
   input wire logic rst_n_i,
   input wire logic bus_enable_i,
   input wire logic read_write_i,
   input wire logic chip_select_a_i,
   input wire logic data_oe_o,
   input wire logic tx_bit_clk_i,
   input wire logic tx_serial_o,
   input wire logic request_to_send_n_o,
   input wire logic irq_n_o,
   input wire logic irq_oe_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   property p_oe_rw; data_oe_o |-> $past(read_write_i, 3); endproperty
   a_oe_rw: assert property (p_oe_rw) else $error("bus driven on write");
   property p_oe_rise; $rose(data_oe_o) |-> $past(bus_enable_i, 2); endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("bus driven without strobe");
   property p_oe_cs; data_oe_o |-> $past(chip_select_a_i, 3); endproperty
   a_oe_cs: assert property (p_oe_cs) else $error("bus driven unselected");
   property p_cs_idle; (!chip_select_a_i) [*6] |-> !data_oe_o; endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("bus driven while idle");
   property p_tx_edge; (tx_bit_clk_i && !chip_select_a_i) [*8] |-> $stable(tx_serial_o); endproperty
   a_tx_edge: assert property (p_tx_edge) else $error("line moved off falling edge");
   property p_rts_cause; $changed(request_to_send_n_o) |-> !$past(read_write_i, 4); endproperty
   a_rts_cause: assert property (p_rts_cause) else $error("rts moved without write");
   property p_power_on; $rose(rst_n_i) |-> (irq_n_o && tx_serial_o) [*4]; endproperty
   a_power_on: assert property (p_power_on) else $error("active outputs at power on");
   property p_irq_pin; irq_oe_o != irq_n_o; endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("irq pin enable mismatch");
endmodule : async_serial_adapter_core_checker

bind async_serial_adapter_core async_serial_adapter_core_checker chk (.*);

/* File: verif/serial_line_partner.sv */
// Purpose: Far end of the serial line: bit clock and loopback.
// Assumes: Transmit and receive share one bit clock.
// Notes: Half period is 10 system clocks.
`timescale 1ns/1ps
module serial_line_partner (
   input wire logic tx_serial_i,
   output logic bit_clk_o,
   output logic rx_serial_o
);
   initial bit_clk_o = 1'b1;
   always #250 bit_clk_o = ~bit_clk_o;
   // The looped data moves with the same clock, so divide-by-one needs no search.
   assign rx_serial_o = tx_serial_i;
endmodule : serial_line_partner

/* File: verif/async_serial_adapter_core_tb_top.sv */
// Purpose: Self-checking bench for the serial adapter core.
// Assumes: Looped-back line, modem inputs held ready.
// Notes: Rows hold config, sent, received, status and rts level.
`timescale 1ns/1ps
module async_serial_adapter_core_tb_top;
   logic mclk_i = 1'b0, rst_n_i = 1'b0, e = 1'b0, rw = 1'b1, rs = 1'b0, cs = 1'b0;
   logic [7:0] din = 8'h00, dout, rd;
   logic oe, bclk, line, txd, rts_n, irq_n, irq_oe;
   int num_errors = 0, compares = 0;
   logic [32:0] rows [6] = '{{8'h54, 8'h55, 8'h55, 8'h03, 1'b1},
      {8'h48, 8'hc8, 8'h48, 8'h03, 1'b1}, {8'h50, 8'h81, 8'h81, 8'h03, 1'b1},
      {8'h84, 8'hff, 8'h7f, 8'h83, 1'b0}, {8'h2d, 8'h3c, 8'h3c, 8'h83, 1'b0},
      {8'h9a, 8'ha5, 8'ha5, 8'h83, 1'b0}};
   always #12.5 mclk_i = ~mclk_i;
   async_serial_adapter_core DUT (.mclk_i, .rst_n_i, .bus_enable_i(e), .read_write_i(rw),
      .register_select_i(rs), .chip_select_a_i(cs), .chip_select_b_i(cs),
      .chip_select_c_n_i(!cs), .data_i(din), .data_o(dout), .data_oe_o(oe),
      .tx_bit_clk_i(bclk), .rx_bit_clk_i(bclk), .rx_serial_i(line),
      .clear_to_send_n_i(1'b0), .carrier_detect_n_i(1'b0), .tx_serial_o(txd),
      .request_to_send_n_o(rts_n), .irq_n_o(irq_n), .irq_oe_o(irq_oe));
   serial_line_partner far_end (.tx_serial_i(txd), .bit_clk_o(bclk), .rx_serial_o(line));
   task automatic tick(input int n);
      repeat (n) @(posedge mclk_i);
      #2;
   endtask : tick
   task automatic bus(input logic sel, s, r, input logic [7:0] d);
      {cs, rs, rw, din} = {sel, s, r, d};
      tick(2);
      e = 1'b1;
      tick(4);
      rd = dout;
      e = 1'b0;
      tick(6);
      cs = 1'b0;
      tick(1);
   endtask : bus
   // Polls status until a character is waiting, pausing so the select lines go idle.
   task automatic poll;
      rd = 8'h00;
      for (int n = 0; n < 1000 && rd[0] !== 1'b1; n++) begin
         bus(1, 0, 1, 8'h00);
         tick(10);
      end
   endtask : poll
   task automatic chk(input logic [7:0] got, exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: saw %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic complete_run;
      $display("%0d compares, %0d errors", compares, num_errors);
      if (num_errors == 0 && compares > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : complete_run
   initial begin
      #(60000 * 25);
      num_errors++;
      complete_run;
   end
   initial begin
      tick(10);
      rst_n_i = 1'b1;
      tick(2);
      chk({4'h0, txd, rts_n, irq_n, oe}, 8'h0a);
      foreach (rows[i]) begin
         bus(1, 0, 0, rows[i][32:25]);
         chk({7'h0, rts_n}, {7'h0, rows[i][0]});
         bus(1, 1, 0, rows[i][24:17]);
         poll();
         chk(rd, rows[i][8:1]);
         bus(1, 1, 1, 8'h00);
         chk(rd, rows[i][16:9]);
         chk({6'h0, irq_oe, irq_n}, {6'h0, rows[i][31:30] == 2'b01, rows[i][31:30] != 2'b01});
         $display("row %0d done", i);
      end
      bus(0, 0, 0, 8'h74);
      chk({6'h0, txd, rts_n}, 8'h02);
      bus(1, 0, 0, 8'h74);
      chk({6'h0, txd, rts_n}, 8'h00);
      bus(1, 0, 0, 8'h03);
      bus(1, 0, 0, 8'h54);
      bus(1, 1, 1, 8'h00);
      chk(rd, 8'ha5);
      bus(1, 0, 1, 8'h00);
      chk(rd, 8'h02);
      bus(1, 1, 0, 8'h11);
      bus(1, 0, 1, 8'h00);
      chk(rd, 8'h02);
      bus(1, 1, 0, 8'h22);
      poll();
      bus(1, 1, 1, 8'h00);
      chk(rd, 8'h11);
      poll();
      bus(1, 1, 1, 8'h00);
      chk(rd, 8'h22);
      // Two characters with no read between them: the second one overruns.
      bus(1, 1, 0, 8'h33);
      bus(1, 1, 0, 8'h44);
      tick(600);
      bus(1, 0, 1, 8'h00);
      chk(rd, 8'h23);
      bus(1, 1, 1, 8'h00);
      chk(rd, 8'h33);
      bus(1, 0, 1, 8'h00);
      chk(rd, 8'h02);
      $display("hand tests done");
      complete_run;
   end
endmodule : async_serial_adapter_core_tb_top
